// >>> csp_cfg.svh
// constants for the clock synthesizer and periodic timer block
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH
`define CSP_OFF_SYNTH 4'h0
`define CSP_OFF_IRQCTL 4'h4
`define CSP_OFF_TMOD 4'h8
`define CSP_OFF_STAT 4'hc
`define CSP_SYNTH_RST 16'h3f00
`define CSP_SYNTH_WMASK 16'hff83
`define CSP_IRQCTL_RST 16'h000f
`define CSP_IRQCTL_WMASK 16'h07ff
`define CSP_TMOD_WMASK 16'h01ff
`define CSP_BIT_W 15
`define CSP_BIT_X 14
`define CSP_Y_HI 13
`define CSP_Y_LO 8
`define CSP_BIT_BUSDIV 7
`define CSP_BIT_LOCK 3
`define CSP_BIT_STSC 1
`define CSP_BIT_STOPOUT 0
`define CSP_LVL_HI 10
`define CSP_LVL_LO 8
`define CSP_BIT_PRESEL 8
`define CSP_LOCK_TIME_NS 20000
`define CSP_CLK_NS 20
`define CSP_REFDIV_MAX 2'h3
`define CSP_PRESCALE_MAX 9'h1ff
`define CSP_SBC_HALF8 3'h3
`define CSP_SBC_HALF16 3'h7
`define CSP_MULT_BASE 3'h2
`endif

// >>> csp_clock_timer.sv
// clock synthesizer control, stop clocking and periodic interrupt timer
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "csp_cfg.svh"

// Operation
// [R1] strap low at reset: synthesizer off, system clock from external input
// [R2] strap high at reset: synthesizer makes system clock from reference
// [R3] output divide bit: clear gives vco/4, set gives vco/2, no relock
// [R4] fsys = fref/128 * 4 * (modulus+1) * 2^(2*tap + divide bit)
// [R5] synth_control resets to 3f00, lock flag undefined
// [R6] device held in reset at power-up until synthesizer locks
// [R7] any phase comparator input change forces a relock interval
// [R8] prescale tap bit 15 multiplies vco by four, needs relock
// [R9] six-bit feedback modulus multiplies by value plus one, relocks
// [R10] lock flag bit 3 shows lock only after first control write
// [R11] software keeps reserved control bits at zero
// [R12] bus divide bit: slow bus clock is fsys/8 clear, fsys/16 set
// [R13] stop: core clock bit clear uses crystal and stops vco
// [R14] stop: output bit clear holds clock pin low, else drives it
// [R15] synth_control readable and writable at any time
// [R16] periodic control bits 10:0 read/write, bits 15:11 read zero
// [R17] request level 000 disables, others request at that level
// [R18] periodic request wins over equal-level external request
// [R19] timer keeps counting while request level is zero
// [R20] acknowledged periodic interrupt returns eight-bit vector
// [R21] modulus zero stops timer; timer register always accessible
// [R22] prescale bit 8 divides by 512; resets to inverted strap
// [R23] period is modulus times prescale times four reference clocks
// [R24] timer counts down, requests on expiry, reloads modulus
module csp_clock_timer (
  input wire logic i_clk, // system clock, 50 MHz
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic i_clock_source_strap, // clock mode strap
  input wire logic i_ref_tick, // one pulse per reference clock period
  input wire logic i_low_power_stop_instr, // low power stop active
  input wire logic i_ext_irq_pending, // external request at iack level
  input wire csp_pkg::csp_iack_s i_iack, // interrupt acknowledge cycle
  input wire csp_pkg::csp_avs_req_s i_avs, // avalon request
  output logic [31:0] o_avs_readdata, // avalon read data
  output logic o_avs_waitrequest, // avalon wait request
  output logic o_core_reset_hold, // keeps the rest of the chip in reset
  output logic o_synth_enable, // synthesizer powered and in use
  output logic o_vco_enable, // vco running
  output logic o_core_clk_from_vco, // core clock taken from vco
  output logic o_sys_from_ext, // system clock straight from ext input
  output logic [11:0] o_freq_mult, // fsys/fref times 128
  output logic o_sys_div_half, // output divider is vco/2
  output logic o_slow_bus_clock, // slow external bus clock
  output logic o_clock_output_pin, // clock output pin level
  output logic [2:0] o_irq_level, // periodic request level, 0 idle
  output logic o_timer_claim, // periodic timer answers this iack
  output logic o_ext_ack_allowed, // external source may answer iack
  output logic o_vector_valid, // vector on bus, one cycle
  output logic [7:0] o_vector // periodic vector
);

  localparam int LOCK_CYCLES =
    (`CSP_LOCK_TIME_NS + `CSP_CLK_NS - 1) / `CSP_CLK_NS;
  localparam logic [10:0] LOCK_MAX = 11'(LOCK_CYCLES);

  logic strap_reg;
  logic [15:0] synth_reg;
  logic [15:0] synth_next;
  logic [15:0] irqctl_reg;
  logic [15:0] irqctl_next;
  logic [15:0] tmod_reg;
  logic [15:0] tmod_next;
  logic written_reg;
  logic [10:0] lock_cnt_reg;
  logic locked;
  logic powered_reg;
  logic relock;
  logic vco_stopped_reg;
  logic [2:0] sbc_cnt_reg;
  logic sbc_reg;
  logic [1:0] refdiv_reg;
  logic [8:0] pre_reg;
  logic quarter_tick;
  logic tmr_tick;
  logic [7:0] cnt_reg;
  logic expire;
  logic pend_reg;
  logic ack_hit;
  logic [15:0] be_mask;
  logic [15:0] rd_word;
  logic wr_synth;
  logic wr_irqctl;
  logic wr_tmod;
  logic take;
  csp_pkg::csp_bus_e bus_reg;

  // clock source strap caught while reset is held
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      strap_reg <= i_clock_source_strap; // [R1] [R2]
  end

  // bus access handshake: one wait cycle, then answer
  assign take = (i_avs.read | i_avs.write) & (bus_reg == csp_pkg::CSP_BUS_ANSWER);
  assign o_avs_waitrequest = (i_avs.read | i_avs.write) & ~take;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      bus_reg <= csp_pkg::CSP_BUS_IDLE;
    else
    begin
      unique case (bus_reg)
        csp_pkg::CSP_BUS_IDLE:
        begin
          if (i_avs.read | i_avs.write)
            bus_reg <= csp_pkg::CSP_BUS_ANSWER;
        end
        csp_pkg::CSP_BUS_ANSWER:
          bus_reg <= csp_pkg::CSP_BUS_IDLE;
      endcase
    end
  end

  // byte lane mask for the low sixteen bits
  assign be_mask = {{8{i_avs.byteenable[1]}}, {8{i_avs.byteenable[0]}}};
  assign wr_synth = take & i_avs.write & (i_avs.address == `CSP_OFF_SYNTH);
  assign wr_irqctl = take & i_avs.write &
    (i_avs.address == `CSP_OFF_IRQCTL);
  assign wr_tmod = take & i_avs.write & (i_avs.address == `CSP_OFF_TMOD);

  // next values of the writable registers, reserved bits kept zero
  always_comb
  begin
    synth_next = (synth_reg & ~(be_mask & `CSP_SYNTH_WMASK)) |
      (i_avs.writedata[15:0] & be_mask & `CSP_SYNTH_WMASK); // [R11]
    irqctl_next = (irqctl_reg & ~(be_mask & `CSP_IRQCTL_WMASK)) |
      (i_avs.writedata[15:0] & be_mask & `CSP_IRQCTL_WMASK); // [R16]
    tmod_next = (tmod_reg & ~(be_mask & `CSP_TMOD_WMASK)) |
      (i_avs.writedata[15:0] & be_mask & `CSP_TMOD_WMASK); // [R21]
  end

  // synthesizer control register, writable at any time
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      synth_reg <= `CSP_SYNTH_RST; // [R5]
    else if (wr_synth)
      synth_reg <= synth_next; // [R15]
  end

  // first write arms the lock flag
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      written_reg <= 1'b0;
    else if (wr_synth)
      written_reg <= 1'b1; // [R10]
  end

  // periodic control register
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      irqctl_reg <= `CSP_IRQCTL_RST;
    else if (wr_irqctl)
      irqctl_reg <= irqctl_next; // [R16]
  end

  // periodic timer register, prescale bit from inverted strap
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      tmod_reg <= '0;
      tmod_reg[`CSP_BIT_PRESEL] <= ~i_clock_source_strap; // [R22]
    end
    else if (wr_tmod)
      tmod_reg <= tmod_next; // [R21]
  end

  // relock on tap or modulus change, or vco restart after stop
  assign relock = (wr_synth &
    ((synth_next[`CSP_BIT_W] != synth_reg[`CSP_BIT_W]) |
     (synth_next[`CSP_Y_HI:`CSP_Y_LO] != synth_reg[`CSP_Y_HI:`CSP_Y_LO]))) |
    (vco_stopped_reg & ~i_low_power_stop_instr); // [R7] [R8] [R9]

  // lock interval counter; external clock counts as locked
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      lock_cnt_reg <= '0;
    else if (relock)
      lock_cnt_reg <= '0; // [R7]
    else if (lock_cnt_reg != LOCK_MAX)
      lock_cnt_reg <= lock_cnt_reg + 11'h001;
  end
  assign locked = ~strap_reg | (lock_cnt_reg == LOCK_MAX); // [R1]

  // vco off during stop when core runs from the crystal
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      vco_stopped_reg <= 1'b0;
    else
      vco_stopped_reg <= strap_reg & i_low_power_stop_instr &
        ~synth_reg[`CSP_BIT_STSC]; // [R13]
  end

  // power-up hold released on first lock only
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      powered_reg <= 1'b0;
    else if (locked)
      powered_reg <= 1'b1; // [R6]
  end
  assign o_core_reset_hold = i_sys_rst | ~powered_reg; // [R6]

  // clock source and frequency steering outputs
  assign o_synth_enable = strap_reg; // [R1] [R2]
  assign o_sys_from_ext = ~strap_reg; // [R1]
  assign o_vco_enable = strap_reg & ~vco_stopped_reg; // [R13]
  assign o_core_clk_from_vco = strap_reg &
    ~(i_low_power_stop_instr & ~synth_reg[`CSP_BIT_STSC]); // [R13]
  assign o_sys_div_half = synth_reg[`CSP_BIT_X]; // [R3]
  // 4*(y+1) shifted by 2w+x, all over 128, scaled by 128
  assign o_freq_mult = (12'(synth_reg[`CSP_Y_HI:`CSP_Y_LO]) + 12'h001) <<
    (`CSP_MULT_BASE + 3'({synth_reg[`CSP_BIT_W], 1'b0}) +
     3'(synth_reg[`CSP_BIT_X])); // [R4]

  // slow bus clock divider, half period 4 or 8 system clocks
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sbc_cnt_reg <= '0;
      sbc_reg <= 1'b0;
    end
    else if (sbc_cnt_reg == (synth_reg[`CSP_BIT_BUSDIV] ?
             `CSP_SBC_HALF16 : `CSP_SBC_HALF8))
    begin
      sbc_cnt_reg <= '0; // [R12]
      sbc_reg <= ~sbc_reg;
    end
    else
      sbc_cnt_reg <= sbc_cnt_reg + 3'h1;
  end
  assign o_slow_bus_clock = sbc_reg;

  // clock output pin gated during stop
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_clock_output_pin <= 1'b0;
    else if (i_low_power_stop_instr & ~synth_reg[`CSP_BIT_STOPOUT])
      o_clock_output_pin <= 1'b0; // [R14]
    else
      o_clock_output_pin <= ~o_clock_output_pin; // [R14]
  end

  // reference divided by four
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      refdiv_reg <= '0;
    else if (i_ref_tick)
      refdiv_reg <= refdiv_reg + 2'h1; // [R23]
  end
  assign quarter_tick = i_ref_tick & (refdiv_reg == `CSP_REFDIV_MAX);

  // optional divide by 512
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      pre_reg <= '0;
    else if (quarter_tick)
      pre_reg <= pre_reg + 9'h001; // [R22]
  end
  assign tmr_tick = quarter_tick &
    (~tmod_reg[`CSP_BIT_PRESEL] | (pre_reg == `CSP_PRESCALE_MAX)); // [R22]

  // modulus down counter, stopped by a zero modulus
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      cnt_reg <= '0;
    else if (tmod_reg[7:0] == 8'h00)
      cnt_reg <= '0; // [R21]
    else if (tmr_tick)
    begin
      if (cnt_reg <= 8'h01)
        cnt_reg <= tmod_reg[7:0]; // [R24]
      else
        cnt_reg <= cnt_reg - 8'h01; // [R19]
    end
  end
  assign expire = tmr_tick & (cnt_reg == 8'h01) &
    (tmod_reg[7:0] != 8'h00); // [R24]

  // acknowledge matches the pending periodic level
  assign ack_hit = i_iack.valid & pend_reg &
    (i_iack.level == irqctl_reg[`CSP_LVL_HI:`CSP_LVL_LO]);

  // pending request: expiry sets, acknowledge clears, set wins
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      pend_reg <= 1'b0;
    else if (expire & (irqctl_reg[`CSP_LVL_HI:`CSP_LVL_LO] != 3'h0))
      pend_reg <= 1'b1; // [R17] [R24]
    else if (ack_hit | (irqctl_reg[`CSP_LVL_HI:`CSP_LVL_LO] == 3'h0))
      pend_reg <= 1'b0; // [R17]
  end
  assign o_irq_level = pend_reg ?
    irqctl_reg[`CSP_LVL_HI:`CSP_LVL_LO] : 3'h0; // [R17]

  // arbitration: periodic timer beats equal external request
  assign o_timer_claim = ack_hit; // [R18]
  assign o_ext_ack_allowed = i_iack.valid & i_ext_irq_pending &
    ~ack_hit; // [R18]

  // vector returned one cycle after a claimed acknowledge
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_vector_valid <= 1'b0;
      o_vector <= '0;
    end
    else
    begin
      o_vector_valid <= ack_hit; // [R20]
      if (ack_hit)
        o_vector <= irqctl_reg[7:0]; // [R20]
    end
  end

  // read word with lock flag gated until first write
  always_comb
  begin
    rd_word = '0;
    unique case (i_avs.address)
      `CSP_OFF_SYNTH:
      begin
        rd_word = synth_reg;
        rd_word[`CSP_BIT_LOCK] = written_reg & locked; // [R10]
      end
      `CSP_OFF_IRQCTL: rd_word = irqctl_reg; // [R16]
      `CSP_OFF_TMOD: rd_word = tmod_reg;
      `CSP_OFF_STAT: rd_word = {cnt_reg, 4'h0, pend_reg, powered_reg,
                                locked, strap_reg};
      default: rd_word = '0;
    endcase
  end

  // read data captured in the wait cycle, stands at the answer
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_avs_readdata <= '0;
    else if (bus_reg == csp_pkg::CSP_BUS_IDLE)
      o_avs_readdata <= {16'h0000, rd_word};
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // level change by software in the expiry cycle is left out
  sequence s_expire_armed;
    expire && irqctl_reg[10:8] != 3'h0 && !wr_irqctl;
  endsequence
  sequence s_level_shown;
    ##1 o_irq_level == $past(irqctl_reg[10:8]);
  endsequence

  a_timer_request: assert property (s_expire_armed |-> s_level_shown) // [R17]
    else $error("periodic request level not raised on expiry");
  a_level_zero_quiet: assert property (irqctl_reg[10:8] == 3'h0 |=>
    o_irq_level == 3'h0 || $past(expire)) // [R17]
    else $error("request raised while disabled");
  a_zero_stops: assert property (tmod_reg[7:0] == 8'h00 |=> cnt_reg == 8'h00)
    else $error("timer runs with zero modulus"); // [R21]
  a_reload_mod: assert property (expire && !wr_tmod |=>
    cnt_reg == $past(tmod_reg[7:0])) // [R24]
    else $error("modulus not reloaded on expiry");
  a_count_disabled: assert property (tmr_tick && cnt_reg > 8'h01 &&
    tmod_reg[7:0] != 8'h00 |=> cnt_reg == $past(cnt_reg) - 8'h01) // [R19]
    else $error("timer stalled");
  a_vector_out: assert property (ack_hit |=> o_vector_valid &&
    o_vector == $past(irqctl_reg[7:0])) // [R20]
    else $error("vector not returned on acknowledge");
  a_timer_first: assert property (ack_hit |-> !o_ext_ack_allowed) // [R18]
    else $error("external request served before periodic one");
  a_relock_drop: assert property (relock && strap_reg |=> !locked) // [R7]
    else $error("no relock interval after comparator change");
  a_lock_gate: assert property (!written_reg && take && i_avs.read &&
    i_avs.address == 4'h0 |-> o_avs_readdata[3] == 1'b0) // [R10]
    else $error("lock flag shown before first write");
  a_ext_locked: assert property (!strap_reg |-> locked && o_sys_from_ext)
    else $error("external clock not treated as locked"); // [R1]
  a_hold_reset: assert property (!powered_reg |-> o_core_reset_hold) // [R6]
    else $error("core left reset before lock");
  a_clock_output_pin_stop: assert property (i_low_power_stop_instr &&
    !synth_reg[0] |=> !o_clock_output_pin) // [R14]
    else $error("clock output not held in stop");
  a_pic_upper: assert property (irqctl_reg[15:11] == 5'h00) // [R16]
    else $error("unimplemented control bits set");
  a_x_no_relock: assert property (wr_synth && synth_next[15] ==
    synth_reg[15] && synth_next[13:8] == synth_reg[13:8] &&
    !vco_stopped_reg |-> !relock) // [R3]
    else $error("divide change caused relock");

endmodule : csp_clock_timer
`default_nettype wire

// >>> csp_clock_timer_bench.sv
// self-checking bench for the clock synthesizer and periodic timer
`timescale 1ns/1ps
`default_nettype none
`include "csp_cfg.svh"
module csp_clock_timer_bench;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic strap = 1'b1;
  logic ref_run = 1'b1;
  logic stop = 1'b0;
  logic ext_pend = 1'b1;
  csp_pkg::csp_iack_s iack = '0;
  csp_pkg::csp_avs_req_s avs = '0;
  logic ref_tick, wreq, hold, synth_en, vco_en, from_vco, from_ext;
  logic div_half, sbc, clk_pin, claim, ext_ok, vvalid;
  logic [31:0] rdata, q, q2;
  logic [11:0] mult;
  logic [2:0] irq_lvl;
  logic [7:0] vec;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n, t1, t2;

  csp_ref_source #(.DIV(2)) ref_u (.i_clk(i_clk), .i_run(ref_run),
    .o_ref_tick(ref_tick));
  csp_clock_timer dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_clock_source_strap(strap), .i_ref_tick(ref_tick),
    .i_low_power_stop_instr(stop), .i_ext_irq_pending(ext_pend),
    .i_iack(iack), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_core_reset_hold(hold),
    .o_synth_enable(synth_en), .o_vco_enable(vco_en),
    .o_core_clk_from_vco(from_vco), .o_sys_from_ext(from_ext),
    .o_freq_mult(mult), .o_sys_div_half(div_half),
    .o_slow_bus_clock(sbc), .o_clock_output_pin(clk_pin),
    .o_irq_level(irq_lvl), .o_timer_claim(claim),
    .o_ext_ack_allowed(ext_ok),
    .o_vector_valid(vvalid), .o_vector(vec));

  // 50 MHz clock
  always #10 i_clk = ~i_clk;

  // hang guard
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      $display("FAIL %0t timeout", $time);
      report_and_stop();
    end
  end

  // verdict and end of run
  task automatic report_and_stop();
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one avalon cycle, held until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [15:0] d, output logic [31:0] r);
    @(posedge i_clk);
    avs <= '{address: a, read: !wr, write: wr, writedata: {16'h0, d},
             byteenable: 4'h3};
    do
      @(posedge i_clk);
    while (wreq !== 1'b0);
    r = rdata;
    avs <= '0;
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, a, d, q2);
  endtask : wr

  // acknowledge cycle with external source also pending
  task automatic ack(input logic [2:0] l, input logic c, input logic [7:0] v);
    @(posedge i_clk);
    iack <= '{valid: 1'b1, level: l};
    @(negedge i_clk);
    chk({claim, ext_ok}, {c, !c});
    @(posedge i_clk);
    iack <= '0;
    @(negedge i_clk);
    chk(vvalid, c);
    if (c)
      chk(vec, v);
  endtask : ack

  // wait for a request level, return the cycle stamp
  task automatic wait_lvl(input logic [2:0] l, output int t);
    int k;
    k = 0;
    do
    begin
      @(negedge i_clk);
      k++;
    end
    while (irq_lvl !== l && k < 400);
    t = cyc;
  endtask : wait_lvl

  // cycles between two rises of the slow bus clock
  task automatic sbc_period(output int p);
    int k, t0;
    logic last;
    k = 0;
    t0 = 0;
    p = 0;
    last = sbc;
    while (k < 2 && p < 100)
    begin
      @(negedge i_clk);
      p++;
      if (sbc && !last)
      begin
        k++;
        if (k == 1)
          t0 = p;
      end
      last = sbc;
    end
    p = p - t0;
  endtask : sbc_period

  // main sequence
  initial
  begin
    repeat (8) @(posedge i_clk);
    chk(hold, 1'b1);
    i_sys_rst <= 1'b0;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while (hold !== 1'b0 && n < 1500);
    chk(n > 990 && n < 1010, 1);
    chk({synth_en, from_ext}, 2'b10);
    chk({mult, div_half}, {12'h100, 1'b0});
    rd(`CSP_OFF_SYNTH, 32'h3f00);
    rd(`CSP_OFF_IRQCTL, 32'h000f);
    rd(`CSP_OFF_TMOD, 32'h0000);
    rd(4'h2, 32'h0);
    // reserved bits kept clear by software
    wr(`CSP_OFF_SYNTH, 16'h8183);
    rd(`CSP_OFF_SYNTH, 32'h8183);
    chk(mult, 12'h020);
    repeat (1100) @(posedge i_clk);
    rd(`CSP_OFF_SYNTH, 32'h818b);
    wr(`CSP_OFF_SYNTH, 16'hc183);
    rd(`CSP_OFF_SYNTH, 32'hc18b);
    chk({mult, div_half}, {12'h040, 1'b1});
    sbc_period(n);
    chk(n, 16);
    wr(`CSP_OFF_SYNTH, 16'hc103);
    rd(`CSP_OFF_SYNTH, 32'hc10b);
    sbc_period(n);
    chk(n, 8);
    // stop with vco kept and clock pin running
    @(posedge i_clk);
    stop <= 1'b1;
    repeat (3) @(negedge i_clk);
    chk({from_vco, vco_en}, 2'b11);
    n = clk_pin;
    @(negedge i_clk);
    chk(clk_pin ^ n[0], 1'b1);
    @(posedge i_clk);
    stop <= 1'b0;
    wr(`CSP_OFF_SYNTH, 16'hc100);
    stop <= 1'b1;
    repeat (3) @(negedge i_clk);
    chk({from_vco, vco_en, clk_pin}, 3'b000);
    @(negedge i_clk);
    chk(clk_pin, 1'b0);
    @(posedge i_clk);
    stop <= 1'b0;
    wr(`CSP_OFF_IRQCTL, 16'hffff);
    rd(`CSP_OFF_IRQCTL, 32'h07ff);
    // every request level with its own vector
    wr(`CSP_OFF_TMOD, 16'h0001);
    for (int l = 1; l < 8; l++)
    begin
      wr(`CSP_OFF_IRQCTL, {5'h0, l[2:0], 8'h50 + 8'(l)});
      wait_lvl(l[2:0], t1);
      chk(irq_lvl, l[2:0]);
      ack(l[2:0] - 3'h1, 1'b0, 8'h0);
      ack(l[2:0], 1'b1, 8'h50 + 8'(l));
    end
    // period of modulus three without prescale, old request cleared first
    wr(`CSP_OFF_IRQCTL, 16'h00a5);
    wr(`CSP_OFF_TMOD, 16'h0003);
    wr(`CSP_OFF_IRQCTL, 16'h03a5);
    wait_lvl(3'h3, t1);
    ack(3'h3, 1'b1, 8'ha5);
    wait_lvl(3'h3, t2);
    chk(t2 - t1, 24);
    // level zero: no request over at least one expiry, count still moving
    wr(`CSP_OFF_IRQCTL, 16'h00a5);
    bus(1'b0, `CSP_OFF_STAT, 16'h0, q);
    repeat (30) @(posedge i_clk);
    bus(1'b0, `CSP_OFF_STAT, 16'h0, q2);
    chk(q[15:8] != q2[15:8], 1);
    chk(irq_lvl, 3'h0);
    wr(`CSP_OFF_TMOD, 16'h0000);
    repeat (20) @(posedge i_clk);
    bus(1'b0, `CSP_OFF_STAT, 16'h0, q);
    repeat (20) @(posedge i_clk);
    bus(1'b0, `CSP_OFF_STAT, 16'h0, q2);
    chk(q[15:8], q2[15:8]);
    // second reset with the strap low
    i_sys_rst <= 1'b1;
    strap <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk({hold, from_ext, synth_en}, 3'b010);
    rd(`CSP_OFF_TMOD, 32'h0100);
    wr(`CSP_OFF_SYNTH, 16'h3f00);
    rd(`CSP_OFF_SYNTH, 32'h3f08);
    report_and_stop();
  end
endmodule : csp_clock_timer_bench
`default_nettype wire

// >>> csp_pkg.sv
// types shared by the clock synthesizer and periodic timer block
package csp_pkg;
  // bus access handshake states, gray coded
  typedef enum logic [1:0] {
    CSP_BUS_IDLE = 2'b00,
    CSP_BUS_ANSWER = 2'b01
  } csp_bus_e;
  // avalon request as seen by the slave
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } csp_avs_req_s;
  // interrupt acknowledge cycle from the processor
  typedef struct packed {
    logic valid;
    logic [2:0] level;
  } csp_iack_s;
endpackage : csp_pkg

// >>> csp_ref_source.sv
// reference clock source model feeding the periodic timer time base
`timescale 1ns/1ps
`default_nettype none
module csp_ref_source #(
  parameter int DIV = 2 // system clocks per reference period
) (
  input wire logic i_clk, // system clock
  input wire logic i_run, // reference oscillator running
  output logic o_ref_tick // one pulse per reference period
);
  int cnt_reg;
  // one pulse every DIV clocks, silent while stopped
  always_ff @(posedge i_clk)
  begin
    if (!i_run)
    begin
      cnt_reg <= 0;
      o_ref_tick <= 1'b0;
    end
    else
    begin
      cnt_reg <= (cnt_reg == DIV - 1) ? 0 : cnt_reg + 1;
      o_ref_tick <= (cnt_reg == DIV - 1);
    end
  end
endmodule : csp_ref_source
`default_nettype wire
